//--- lpmlat_defs.svh
// Offsets, field positions, reset values and latency figures for the latency block
`ifndef LPMLAT_DEFS_SVH
`define LPMLAT_DEFS_SVH

// ----------------------------------------
// Register word offsets (byte addresses)
// ----------------------------------------
`define LPMLAT_REG_LATENCY 8'h00
`define LPMLAT_REG_CTRL 8'h04

// ----------------------------------------
// Latency register field positions
// ----------------------------------------
`define LPMLAT_EP_MSB 10
`define LPMLAT_EP_LSB 8
`define LPMLAT_RSVD_MSB 7
`define LPMLAT_RSVD_LSB 6
`define LPMLAT_STBY_MSB 5
`define LPMLAT_STBY_LSB 3
`define LPMLAT_L1_MSB 2
`define LPMLAT_L1_LSB 0

// ----------------------------------------
// Control register bit positions
// ----------------------------------------
`define LPMLAT_CTRL_COMMON_CLK 0
`define LPMLAT_CTRL_STBY_FLAG 1
`define LPMLAT_CTRL_L1_FLAG 2

// ----------------------------------------
// Reset and default codes
// ----------------------------------------
`define LPMLAT_CODE_COMMON 3'h3
`define LPMLAT_CODE_SEPARATE 3'h4
`define LPMLAT_L1_DEFAULT 3'h4
`define LPMLAT_EP_DEFAULT 3'h0
`define LPMLAT_COMMON_CLK_RESET 1'h0

// ----------------------------------------
// Lower bound of each exit latency range, ns
// ----------------------------------------
`define LPMLAT_NS_0 16'h0000
`define LPMLAT_NS_64 16'h0040
`define LPMLAT_NS_128 16'h0080
`define LPMLAT_NS_256 16'h0100
`define LPMLAT_NS_512 16'h0200
`define LPMLAT_NS_1000 16'h03E8
`define LPMLAT_NS_2000 16'h07D0
`define LPMLAT_NS_4000 16'h0FA0

`endif

//--- lpmlat_pkg.sv
// Types shared by the latency register block
package lpmlat_pkg;

	// Three-bit latency code as carried on every field
	typedef logic [2:0] lpmlat_code_type;

	// State of one tracked latency field
	typedef struct packed
	{
		logic flag;
		lpmlat_code_type code;
	} lpmlat_field_type;

	// State of the register block top
	typedef struct packed
	{
		logic common_clk;
		lpmlat_code_type ep_code;
		logic ack;
		logic [31:0] rdata;
		logic [15:0] floor_ns;
	} lpmlat_top_type;

endpackage

//--- lpmlat_field.sv
// One latency code field with its software-written tracking flag
`timescale 1ns/1ns
module lpmlat_field
#(
	parameter lpmlat_pkg::lpmlat_code_type RESET_CODE = 3'h4
)
(
	// Clock and reset
	input wire logic clk_i,
	input wire logic rst_i,
	// Write port from bus or loader
	input wire logic wr_en_i,
	input wire lpmlat_pkg::lpmlat_code_type wr_data_i,
	// Value followed while never written
	input wire lpmlat_pkg::lpmlat_code_type dflt_i,
	// Field state
	output lpmlat_pkg::lpmlat_code_type code_o,
	output logic flag_o
);
	import lpmlat_pkg::*;

	lpmlat_field_type st_r;
	lpmlat_field_type st_nxt;
	logic wr_diff;

	// ----------------------------------------
	// Next state
	// ----------------------------------------

	// Only a write that changes the value counts as software ownership
	assign wr_diff = wr_en_i && (wr_data_i != st_r.code);

	always_comb
	begin
		st_nxt = st_r;
		if (wr_diff)
		begin
			st_nxt.flag = 1'b1;
			st_nxt.code = wr_data_i;
		end
		else if (!st_r.flag)
		begin
			// Follows the default one cycle late, never combinationally
			st_nxt.code = dflt_i;
		end
	end

	// Flag clears on reset alone
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			st_r.flag <= 1'b0;
			st_r.code <= RESET_CODE;
		end
		else
		begin
			st_r <= st_nxt;
		end
	end

	assign code_o = st_r.code;
	assign flag_o = st_r.flag;

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);

	property p_flag_set;
		wr_en_i && (wr_data_i != code_o) |=> flag_o && (code_o == $past(wr_data_i));
	endproperty
	a_flag_set: assert property (p_flag_set)
		else $error("flag not set by differing write");

	property p_flag_sticky;
		flag_o |=> flag_o;
	endproperty
	a_flag_sticky: assert property (p_flag_sticky)
		else $error("flag cleared without reset");

	property p_hold_owned;
		flag_o && !wr_en_i |=> $stable(code_o);
	endproperty
	a_hold_owned: assert property (p_hold_owned)
		else $error("owned field changed without write");

	property p_same_write;
		!flag_o && wr_en_i && (wr_data_i == code_o) |=> !flag_o;
	endproperty
	a_same_write: assert property (p_same_write)
		else $error("flag set by unchanged write");

endmodule

//--- lpmlat_regs.sv
// Link power-management latency register block on a Wishbone slave
`timescale 1ns/1ns
`include "lpmlat_defs.svh"

// Summary of operation
// - EEPROM preloads fields; fundamental reset restores defaults
// - Bits 7:6 read zero, ignore writes
// - Bits 5:3 standby exit code, drives capability
// - Codes 000-011: under 64ns to 512ns
// - Codes 100-111: 512ns up to over 4us
// - Tracking flag set by differing write, reset-cleared
// - Unwritten with common clock reads 011b
// - Unwritten with separate clocks reads 100b
// - Written field holds value, ignores clock mode
// - Bits 10:8 endpoint acceptable latency, drives capability
module lpmlat_regs
#(
	parameter int ADDR_W = 8
)
(
	// Clock and reset
	input wire logic clk_i,
	input wire logic rst_i,
	// Wishbone classic slave
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [ADDR_W-1:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	// Serial EEPROM loader write port
	input wire logic eeprom_present_i,
	input wire logic eeprom_load_i,
	input wire logic [10:0] eeprom_load_data_i,
	// Capability and link outputs
	output lpmlat_pkg::lpmlat_code_type standby_exit_latency_code_o,
	output lpmlat_pkg::lpmlat_code_type l1_exit_latency_code_o,
	output lpmlat_pkg::lpmlat_code_type endpoint_sleep_accept_latency_o,
	output logic common_clock_config_bit_o,
	output logic [15:0] standby_exit_floor_ns_o
);
	import lpmlat_pkg::*;

	// ----------------------------------------
	// Elaboration check
	// ----------------------------------------
	generate
		if (ADDR_W < 3)
		begin : g_bad_addr
			$error("ADDR_W too small for two registers");
		end
	endgenerate

	// ----------------------------------------
	// Functions
	// ----------------------------------------

	// Word decode; low two address bits ignored as for any word register
	function automatic logic reg_hit(input logic [ADDR_W-1:0] adr, input logic [7:0] off);
		logic [ADDR_W-1:0] full;
		full = ADDR_W'(off);
		return adr[ADDR_W-1:2] == full[ADDR_W-1:2];
	endfunction

	// Lowest exit time of each code's range, for PHY timers
	function automatic logic [15:0] exit_floor_ns(input lpmlat_code_type code);
		logic [15:0] ns;
		ns = `LPMLAT_NS_0;
		case (code)
			3'h0: ns = `LPMLAT_NS_0;
			3'h1: ns = `LPMLAT_NS_64;
			3'h2: ns = `LPMLAT_NS_128;
			3'h3: ns = `LPMLAT_NS_256;
			3'h4: ns = `LPMLAT_NS_512;
			3'h5: ns = `LPMLAT_NS_1000;
			3'h6: ns = `LPMLAT_NS_2000;
			3'h7: ns = `LPMLAT_NS_4000;
		endcase
		return ns;
	endfunction

	// ----------------------------------------
	// Declarations
	// ----------------------------------------
	lpmlat_top_type st_r;
	lpmlat_top_type st_nxt;
	logic req;
	logic lat_hit;
	logic ctrl_hit;
	logic ee_wr;
	logic bus_lat_wr;
	logic low_wr_en;
	lpmlat_code_type stby_wdata;
	lpmlat_code_type l1_wdata;
	lpmlat_code_type stby_dflt;
	lpmlat_code_type stby_code;
	lpmlat_code_type l1_code;
	logic stby_flag;
	logic l1_flag;

	// ----------------------------------------
	// Request decode
	// ----------------------------------------

	// New request only while no ack is out, so each access acks once
	assign req = wb_cyc_i && wb_stb_i && !st_r.ack;
	assign lat_hit = reg_hit(wb_adr_i, `LPMLAT_REG_LATENCY);
	assign ctrl_hit = reg_hit(wb_adr_i, `LPMLAT_REG_CTRL);

	// Loader wins a tie; it runs before software owns the bus
	assign ee_wr = eeprom_present_i && eeprom_load_i;
	assign bus_lat_wr = req && wb_we_i && lat_hit && !ee_wr;

	// Low byte lane carries both exit latency fields
	assign low_wr_en = ee_wr || (bus_lat_wr && wb_sel_i[0]);

	// Write data for the tracked fields, from loader or bus
	always_comb
	begin
		if (ee_wr)
		begin
			stby_wdata = eeprom_load_data_i[`LPMLAT_STBY_MSB:`LPMLAT_STBY_LSB];
			l1_wdata = eeprom_load_data_i[`LPMLAT_L1_MSB:`LPMLAT_L1_LSB];
		end
		else
		begin
			stby_wdata = wb_dat_i[`LPMLAT_STBY_MSB:`LPMLAT_STBY_LSB];
			l1_wdata = wb_dat_i[`LPMLAT_L1_MSB:`LPMLAT_L1_LSB];
		end
	end

	// Clock mode picks the unwritten standby value
	assign stby_dflt = st_r.common_clk ? `LPMLAT_CODE_COMMON : `LPMLAT_CODE_SEPARATE;

	// ----------------------------------------
	// Tracked latency fields
	// ----------------------------------------

	// Standby exit latency follows clock mode until written
	lpmlat_field
	#(
		.RESET_CODE(`LPMLAT_CODE_SEPARATE)
	)
	u_stby
	(
		.clk_i(clk_i),
		.rst_i(rst_i),
		.wr_en_i(low_wr_en),
		.wr_data_i(stby_wdata),
		.dflt_i(stby_dflt),
		.code_o(stby_code),
		.flag_o(stby_flag)
	);

	// Sleep exit latency has a fixed unwritten value
	lpmlat_field
	#(
		.RESET_CODE(`LPMLAT_L1_DEFAULT)
	)
	u_l1
	(
		.clk_i(clk_i),
		.rst_i(rst_i),
		.wr_en_i(low_wr_en),
		.wr_data_i(l1_wdata),
		.dflt_i(`LPMLAT_L1_DEFAULT),
		.code_o(l1_code),
		.flag_o(l1_flag)
	);

	// ----------------------------------------
	// Next state of the bus side
	// ----------------------------------------
	always_comb
	begin
		st_nxt = st_r;
		st_nxt.ack = req;
		// Floor tracks the live code one cycle behind
		st_nxt.floor_ns = exit_floor_ns(stby_code);
		// Endpoint field: loader, else bus on byte lane one
		if (ee_wr)
		begin
			st_nxt.ep_code = eeprom_load_data_i[`LPMLAT_EP_MSB:`LPMLAT_EP_LSB];
		end
		else if (bus_lat_wr && wb_sel_i[1])
		begin
			st_nxt.ep_code = wb_dat_i[`LPMLAT_EP_MSB:`LPMLAT_EP_LSB];
		end
		// Clock mode bit stands in for the link control copy
		if (req && wb_we_i && ctrl_hit && wb_sel_i[0])
		begin
			st_nxt.common_clk = wb_dat_i[`LPMLAT_CTRL_COMMON_CLK];
		end
		// Read data; unmapped words and reserved bits read zero
		st_nxt.rdata = 32'h0000_0000;
		if (req && !wb_we_i && lat_hit)
		begin
			st_nxt.rdata[`LPMLAT_EP_MSB:`LPMLAT_EP_LSB] = st_r.ep_code;
			st_nxt.rdata[`LPMLAT_STBY_MSB:`LPMLAT_STBY_LSB] = stby_code;
			st_nxt.rdata[`LPMLAT_L1_MSB:`LPMLAT_L1_LSB] = l1_code;
		end
		else if (req && !wb_we_i && ctrl_hit)
		begin
			st_nxt.rdata[`LPMLAT_CTRL_COMMON_CLK] = st_r.common_clk;
			st_nxt.rdata[`LPMLAT_CTRL_STBY_FLAG] = stby_flag;
			st_nxt.rdata[`LPMLAT_CTRL_L1_FLAG] = l1_flag;
		end
	end

	// Fundamental reset returns everything to its default
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			st_r.common_clk <= `LPMLAT_COMMON_CLK_RESET;
			st_r.ep_code <= `LPMLAT_EP_DEFAULT;
			st_r.ack <= 1'b0;
			st_r.rdata <= 32'h0000_0000;
			st_r.floor_ns <= `LPMLAT_NS_512;
		end
		else
		begin
			st_r <= st_nxt;
		end
	end

	// ----------------------------------------
	// Outputs
	// ----------------------------------------
	assign wb_ack_o = st_r.ack;
	assign wb_dat_o = st_r.rdata;
	assign standby_exit_latency_code_o = stby_code;
	assign l1_exit_latency_code_o = l1_code;
	assign endpoint_sleep_accept_latency_o = st_r.ep_code;
	assign common_clock_config_bit_o = st_r.common_clk;
	assign standby_exit_floor_ns_o = st_r.floor_ns;

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);

	sequence s_bus_lat_wr;
		wb_cyc_i && wb_stb_i && wb_we_i && !wb_ack_o && lat_hit && !ee_wr;
	endsequence

	sequence s_lat_rd;
		wb_cyc_i && wb_stb_i && !wb_we_i && !wb_ack_o && lat_hit;
	endsequence

	property p_reset_dflt;
		$fell(rst_i) |-> standby_exit_latency_code_o == `LPMLAT_CODE_SEPARATE
			&& l1_exit_latency_code_o == `LPMLAT_L1_DEFAULT
			&& endpoint_sleep_accept_latency_o == `LPMLAT_EP_DEFAULT
			&& !common_clock_config_bit_o;
	endproperty
	a_reset_dflt: assert property (p_reset_dflt)
		else $error("defaults wrong after reset");

	property p_ee_load;
		eeprom_present_i && eeprom_load_i |=>
			endpoint_sleep_accept_latency_o == $past(eeprom_load_data_i[10:8]);
	endproperty
	a_ee_load: assert property (p_ee_load)
		else $error("loader value not taken");

	property p_rsvd_zero;
		wb_ack_o |-> wb_dat_o[7:6] == 2'h0 && wb_dat_o[31:11] == 21'h000000;
	endproperty
	a_rsvd_zero: assert property (p_rsvd_zero)
		else $error("reserved bits not zero");

	property p_stby_read;
		s_lat_rd |=> wb_ack_o && wb_dat_o[5:3] == $past(standby_exit_latency_code_o);
	endproperty
	a_stby_read: assert property (p_stby_read)
		else $error("read does not show standby code");

	property p_floor_low;
		standby_exit_latency_code_o == 3'h3 |=> standby_exit_floor_ns_o == `LPMLAT_NS_256;
	endproperty
	a_floor_low: assert property (p_floor_low)
		else $error("floor wrong for code 011");

	property p_floor_high;
		standby_exit_latency_code_o == 3'h7 |=> standby_exit_floor_ns_o == `LPMLAT_NS_4000;
	endproperty
	a_floor_high: assert property (p_floor_high)
		else $error("floor wrong for code 111");

	property p_common_dflt;
		!stby_flag && st_r.common_clk && !low_wr_en |=>
			standby_exit_latency_code_o == `LPMLAT_CODE_COMMON;
	endproperty
	a_common_dflt: assert property (p_common_dflt)
		else $error("unwritten common clock code not 011");

	property p_separate_dflt;
		!stby_flag && !st_r.common_clk && !low_wr_en |=>
			standby_exit_latency_code_o == `LPMLAT_CODE_SEPARATE;
	endproperty
	a_separate_dflt: assert property (p_separate_dflt)
		else $error("unwritten separate clock code not 100");

	property p_ep_write;
		s_bus_lat_wr ##0 wb_sel_i[1] |=>
			wb_ack_o && endpoint_sleep_accept_latency_o == $past(wb_dat_i[10:8]);
	endproperty
	a_ep_write: assert property (p_ep_write)
		else $error("endpoint latency write lost");

endmodule

//--- link_pm_exit_latency_fields_tb.sv
// Self-checking bench for the link power-management latency register block
`timescale 1ns/1ns
`include "lpmlat_defs.svh"
module link_pm_exit_latency_fields_tb;
	import lpmlat_pkg::*;

	// ----------------------------------------
	// Stimulus, observed outputs, reference state
	// ----------------------------------------
	logic clk_i = 1'b0;
	logic rst_i = 1'b1;
	logic wb_cyc_i = 1'b0;
	logic wb_stb_i = 1'b0;
	logic wb_we_i = 1'b0;
	logic [7:0] wb_adr_i = 8'h00;
	logic [3:0] wb_sel_i = 4'h0;
	logic [31:0] wb_dat_i = 32'h0;
	logic eeprom_present_i = 1'b0;
	logic eeprom_load_i = 1'b0;
	logic [10:0] eeprom_load_data_i = 11'h000;
	logic [31:0] wb_dat_o;
	logic wb_ack_o;
	lpmlat_code_type stby_code, l1_code, ep_code;
	logic common_clk;
	logic [15:0] floor_ns;
	lpmlat_code_type m_stby, m_l1, m_ep;
	logic m_fs, m_fl, m_cclk;
	int n_errors = 0;
	int checks_done = 0;
	int seed = 32'he40d;
	// Lower bound of each standby exit range in ns, codes 0 to 7
	logic [15:0] floor_tab [8] = '{16'h0000, 16'h0040, 16'h0080, 16'h0100,
		16'h0200, 16'h03E8, 16'h07D0, 16'h0FA0};

	lpmlat_regs #(.ADDR_W(8)) dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i),
		.wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
		.wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
		.eeprom_present_i(eeprom_present_i), .eeprom_load_i(eeprom_load_i),
		.eeprom_load_data_i(eeprom_load_data_i), .standby_exit_latency_code_o(stby_code),
		.l1_exit_latency_code_o(l1_code), .endpoint_sleep_accept_latency_o(ep_code),
		.common_clock_config_bit_o(common_clk), .standby_exit_floor_ns_o(floor_ns));

	// Free-running 100 MHz clock
	always #5 clk_i = ~clk_i;

	// ----------------------------------------
	// Reference model
	// ----------------------------------------
	// Unwritten standby field follows the clock mode
	function automatic lpmlat_code_type exp_stby();
		return m_fs ? m_stby : (m_cclk ? 3'h3 : 3'h4);
	endfunction

	function automatic lpmlat_code_type exp_l1();
		return m_fl ? m_l1 : 3'h4;
	endfunction

	// Only a differing value counts as a write of a tracked field
	task automatic model_lat(input logic [10:0] d, input logic lo, input logic hi);
		if (lo && d[5:3] !== exp_stby())
		begin
			m_fs = 1'b1;
			m_stby = d[5:3];
		end
		if (lo && d[2:0] !== exp_l1())
		begin
			m_fl = 1'b1;
			m_l1 = d[2:0];
		end
		if (hi)
			m_ep = d[10:8];
	endtask

	// ----------------------------------------
	// Drivers and comparison
	// ----------------------------------------
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		checks_done++;
		if (seen !== exp)
		begin
			n_errors++;
			$display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	// Classic single cycle, held until ack is sampled high
	task automatic wb(input logic [7:0] a, input logic we, input logic [3:0] sel,
		input logic [31:0] d, output logic [31:0] q);
		@(posedge clk_i);
		wb_cyc_i <= 1'b1;
		wb_stb_i <= 1'b1;
		wb_we_i <= we;
		wb_adr_i <= a;
		wb_sel_i <= sel;
		wb_dat_i <= d;
		// No answer time assumed; only the watchdog ends a hang
		do
		begin
			@(posedge clk_i);
		end
		while (wb_ack_o !== 1'b1);
		q = wb_dat_o;
		wb_cyc_i <= 1'b0;
		wb_stb_i <= 1'b0;
	endtask

	task automatic wr_lat(input logic [3:0] sel, input logic [31:0] d);
		logic [31:0] q;
		wb(`LPMLAT_REG_LATENCY, 1'b1, sel, d, q);
		model_lat(d[10:0], sel[0], sel[1]);
	endtask

	// Flag bits of the control word are read-only, so random data is safe
	task automatic wr_ctrl(input logic [3:0] sel, input logic [31:0] d);
		logic [31:0] q;
		wb(`LPMLAT_REG_CTRL, 1'b1, sel, d, q);
		if (sel[0])
			m_cclk = d[0];
	endtask

	// One loader strobe; ignored while no EEPROM is present
	task automatic load(input logic pres, input logic [10:0] d);
		@(posedge clk_i);
		eeprom_present_i <= pres;
		eeprom_load_i <= 1'b1;
		eeprom_load_data_i <= d;
		@(posedge clk_i);
		eeprom_load_i <= 1'b0;
		if (pres)
			model_lat(d, 1'b1, 1'b1);
	endtask

	task automatic do_reset;
		rst_i <= 1'b1;
		repeat (5) @(posedge clk_i);
		rst_i <= 1'b0;
		{m_stby, m_l1, m_ep, m_fs, m_fl, m_cclk} = '0;
	endtask

	// Two edges let the code and then the floor settle
	task automatic check_state;
		logic [31:0] q;
		repeat (2) @(posedge clk_i);
		check(stby_code, exp_stby());
		check(l1_code, exp_l1());
		check(ep_code, m_ep);
		check(common_clk, m_cclk);
		check(floor_ns, floor_tab[exp_stby()]);
		wb(`LPMLAT_REG_LATENCY, 1'b0, 4'hF, 32'h0, q);
		check(q, {21'h0, m_ep, 2'b00, exp_stby(), exp_l1()});
		wb(`LPMLAT_REG_CTRL, 1'b0, 4'hF, 32'h0, q);
		check(q, {29'h0, m_fl, m_fs, m_cclk});
	endtask

	task automatic print_verdict;
		if (n_errors == 0 && checks_done > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask

	// ----------------------------------------
	// Main sequence and watchdog
	// ----------------------------------------
	initial
	begin
		logic [31:0] d, q;
		logic [2:0] k;
		do_reset;
		check_state;
		wr_ctrl(4'h1, 32'h7);
		check_state;
		// Equal standby value with reserved bits set: no standby flag, bits read zero
		wr_lat(4'h1, 32'h000000DB);
		check_state;
		wr_ctrl(4'h1, 32'h0);
		check_state;
		// Every code, with the clock mode set to its low bit after it
		for (int c = 0; c < 8; c++)
		begin
			k = c[2:0];
			wr_lat(4'h3, {21'h0, ~k, 2'b11, k, ~k});
			wr_ctrl(4'h1, {31'h0, k[0]});
			check_state;
		end
		for (int i = 0; i < 40; i++)
		begin
			d = $random(seed);
			k = 3'($random(seed));
			if (d[31])
				wr_lat({1'b0, k}, d); // No deferred-exit settings here, any value fits
			else
				wr_ctrl({1'b0, k}, d);
			check_state;
		end
		wb(8'h08, 1'b1, 4'hF, 32'hFFFFFFFF, q);
		wb(8'h08, 1'b0, 4'hF, 32'h0, q);
		check(q, 32'h0);
		check_state;
		// Fundamental reset mid-run, then the loader
		do_reset;
		check_state;
		load(1'b0, 11'h7FF);
		check_state;
		load(1'b1, 11'h5E9);
		check_state;
		load(1'b1, 11'($random(seed)));
		wr_ctrl(4'h1, 32'h1);
		check_state;
		do_reset;
		check_state;
		print_verdict;
	end

	initial
	begin
		#500000;
		n_errors++;
		print_verdict;
	end
endmodule
